// [rtl/cstsup_pkg.sv]
// Package for the crypto self-test supervisor: test ids, error codes, timing.
// Assumes a 20 MHz system clock and one engine request/answer port.
package cstsup_pkg;
    // Clock rate and interval units
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned MIN_SECONDS = 60;
    localparam longint unsigned CYC_PER_MIN = longint'(CLK_HZ) * longint'(MIN_SECONDS);
    localparam int CYC_W = 31;
    // Interval limits in minutes
    localparam int IVL_W = 20;
    localparam logic [19:0] IVL_MAX = 20'hAE050; // 712784 minutes
    localparam logic [19:0] IVL_OFF = 20'h00000;
    // Test identifiers issued to the engines
    localparam int TID_W = 5;
    localparam logic [4:0] T_SHA256 = 5'h00;
    localparam logic [4:0] T_RSAVER = 5'h01;
    localparam logic [4:0] T_FWSIG = 5'h02;
    localparam logic [4:0] T_AES_ECB_E = 5'h03;
    localparam logic [4:0] T_AES_ECB_D = 5'h04;
    localparam logic [4:0] T_AES_CFB_E = 5'h05;
    localparam logic [4:0] T_AES_CFB_D = 5'h06;
    localparam logic [4:0] T_AES_GCM_E = 5'h07;
    localparam logic [4:0] T_AES_GCM_D = 5'h08;
    localparam logic [4:0] T_KWRAP = 5'h09;
    localparam logic [4:0] T_KUNWRAP = 5'h0A;
    localparam logic [4:0] T_HMAC384 = 5'h0B;
    localparam logic [4:0] T_SHA384 = 5'h0C;
    localparam logic [4:0] T_KAS384 = 5'h0D;
    localparam logic [4:0] T_DRBG_INST = 5'h0E;
    localparam logic [4:0] T_DRBG_GEN = 5'h0F;
    localparam logic [4:0] T_DRBG_RESEED = 5'h10;
    localparam logic [4:0] T_LAST = 5'h10;
    localparam logic [4:0] T_FIRST_KAT = 5'h03;
    localparam logic [4:0] T_PCT = 5'h11;
    localparam logic [4:0] T_FWLOAD = 5'h12;
    // Error codes reported on status and logged
    localparam int ERR_W = 4;
    localparam logic [3:0] ERR_NONE = 4'h0;
    localparam logic [3:0] ERR_PCT = 4'h1;
    localparam logic [3:0] ERR_CRIT = 4'h2;
    localparam logic [3:0] ERR_FW = 4'h3;
    // Error class shown to the command path
    typedef enum logic [1:0] {
        CSTS_CLASS_OK = 2'h0,
        CSTS_CLASS_KEYPAIR = 2'h1,
        CSTS_CLASS_CRIT = 2'h2,
        CSTS_CLASS_FW = 2'h3
    } cstsup_class_t;
    // Supervisor states, Gray along the power-up path
    typedef enum logic [3:0] {
        S_POR = 4'h0,
        S_PRE_REQ = 4'h1,
        S_PRE_WAIT = 4'h3,
        S_RUN = 4'h2,
        S_PER_DRAIN = 4'h6,
        S_PER_REQ = 4'h7,
        S_PER_WAIT = 4'h5,
        S_PCT_WAIT = 4'h4,
        S_LOG = 4'hC,
        S_LOG_WAIT = 4'hD,
        S_CRIT_HALT = 4'hF,
        S_FW_FAIL = 4'hE,
        S_FWL_WAIT = 4'hA
    } cstsup_state_t;
endpackage

// [rtl/cstsup_top.sv]
// Crypto self-test supervisor: sequences power-up and periodic self-tests,
// gates host commands, logs failures and maps them to error states.
// Assumes engines answer each test request with a done pulse and a pass bit,
// and a flash writer that acknowledges one log write with a done pulse.
`timescale 1ns/1ps
// Function
// - Run full pre-operational test set after every power-up.
// - Repeat conditional tests periodically at programmed interval, no command needed.
// - Refuse new host commands while periodic test pending or running.
// - Let queued commands drain before a periodic test starts; hold the buffer during it.
// - Failing known-answer test resets device; key-pair failure does not; passing tests leave no side effect.
// - Record latest self-test error in internal flash for later readout.
// - Known-answer failure: log to flash, then halt until power cycle.
// - Firmware failure: stop, enter flash programming until power cycle or reflash.
// - Key-pair check failure: discard key, return code 0x1, keep running.
// - Verify boot block and firmware signature at power-up.
// - Verify downloaded image signature before accepting it.
// - RSA verify and SHA-256 tests precede firmware integrity check.
// - Random generator tests run before first random output.
// - Cipher modes and key wrap tests; failure is critical.
// - HMAC, SHA-384 and key-agreement tests; failure is critical.
// - Pairwise check after each key-pair generation; failure is temporary. Only a KEYGEN_DONE seen in S_RUN with no test due is checked.
// - Interval in minutes, legal range 1 to 712784.
// - Interval zero disables periodic testing.
module cstsup_top #(
    parameter longint unsigned CYC_PER_MIN_P = cstsup_pkg::CYC_PER_MIN
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [cstsup_pkg::IVL_W-1:0] INTERVAL_MIN,
    input wire logic CMD_VALID,
    output logic CMD_READY,
    input wire logic IOBUF_EMPTY,
    output logic IOBUF_HOLD,
    output logic TEST_REQ,
    output logic [cstsup_pkg::TID_W-1:0] TEST_ID,
    input wire logic TEST_DONE,
    input wire logic TEST_PASS,
    input wire logic KEYGEN_DONE,
    input wire logic FWLOAD_DONE,
    output logic KEY_DISCARD,
    output logic [cstsup_pkg::ERR_W-1:0] OP_ERR_CODE,
    output logic OP_ERR_VALID,
    output logic RNG_ENABLE,
    output logic FW_ACCEPT,
    output logic FLASH_WR,
    output logic [cstsup_pkg::ERR_W-1:0] FLASH_ERR,
    output logic [cstsup_pkg::TID_W-1:0] FLASH_TID,
    input wire logic FLASH_DONE,
    output logic SELF_RESET,
    output logic FLASH_PROG_MODE,
    output logic HALTED,
    output logic TEST_PENDING,
    output logic TESTS_PASSED,
    output cstsup_pkg::cstsup_class_t ERR_CLASS,
    input wire logic NEW_IMAGE_DONE
);
    import cstsup_pkg::*;

    initial begin
        if (CYC_PER_MIN_P < 1 || CYC_PER_MIN_P >= (64'h1 << CYC_W)) begin
            $error("minute count out of range");
        end
    end

    typedef struct packed {
        cstsup_state_t st;
        logic [TID_W-1:0] tid;
        logic periodic;
        logic [CYC_W-1:0] cyc;
        logic [IVL_W-1:0] mins;
        logic due;
        logic [ERR_W-1:0] err;
        logic [TID_W-1:0] err_tid;
        logic passed;
        logic rng_ok;
        logic discard;
        logic op_err;
        logic fw_accept;
        logic self_reset;
        // One-cycle request for the key-pair and download checks
        logic req_pend;
        cstsup_class_t cls;
    } cstsup_reg_t;

    cstsup_reg_t r;
    cstsup_reg_t next_r;

    // Last cycle of one minute; the counter wraps here and bumps the minutes
    localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(CYC_PER_MIN_P - 1);

    // Next-state logic: pulses default low so each lasts one cycle; self_reset is high from the second cycle of S_CRIT_HALT on.
    // The minute timer only runs in RUN, so time spent in tests, logging or
    // handling a key pair does not count against the interval.

    always_comb begin
        next_r = r;
        next_r.discard = 1'b0;
        next_r.op_err = 1'b0;
        next_r.fw_accept = 1'b0;
        next_r.self_reset = 1'b0;
        next_r.req_pend = 1'b0;
        // minute timer
        // Out-of-range settings are treated as off rather than clamped,
        // so a bad programming value can never start a test storm.
        if (INTERVAL_MIN == IVL_OFF || INTERVAL_MIN > IVL_MAX) begin
            next_r.cyc = '0;
            next_r.mins = '0;
        end else if (r.st == S_RUN && !r.due) begin
            if (r.cyc == CYC_LAST) begin
                next_r.cyc = '0;
                if (r.mins + 20'h00001 >= INTERVAL_MIN) begin
                    next_r.due = 1'b1;
                    next_r.mins = '0;
                end else begin
                    next_r.mins = r.mins + 20'h00001;
                end
            end else begin
                next_r.cyc = r.cyc + 31'h00000001;
            end
        end
        unique case (r.st)
            S_POR: begin
                next_r.tid = T_SHA256;
                next_r.periodic = 1'b0;
                next_r.st = S_PRE_REQ;
            end
            S_PRE_REQ, S_PER_REQ: begin
                next_r.st = (r.st == S_PRE_REQ) ? S_PRE_WAIT : S_PER_WAIT;
            end
            S_PRE_WAIT, S_PER_WAIT: begin
                if (TEST_DONE) begin
                    if (!TEST_PASS) begin
                        next_r.err = (r.tid <= T_FWSIG) ? ERR_FW : ERR_CRIT;
                        next_r.err_tid = r.tid;
                        next_r.st = S_LOG;
                    end else if (r.tid == T_LAST) begin
                        next_r.rng_ok = 1'b1;
                        next_r.passed = 1'b1;
                        next_r.cls = CSTS_CLASS_OK;
                        next_r.st = S_RUN;
                        if (r.periodic) begin
                            next_r.due = 1'b0;
                            next_r.cyc = '0;
                            next_r.mins = '0;
                        end
                    end else begin
                        next_r.tid = r.tid + 5'h01;
                        next_r.st = (r.st == S_PRE_WAIT) ? S_PRE_REQ : S_PER_REQ;
                    end
                end
            end
            S_RUN: begin
                if (r.due) begin
                    next_r.st = S_PER_DRAIN;
                    next_r.passed = 1'b0;
                end else if (KEYGEN_DONE) begin
                    // request issued once the id register holds the check
                    next_r.tid = T_PCT;
                    next_r.req_pend = 1'b1;
                    next_r.st = S_PCT_WAIT;
                end else if (FWLOAD_DONE) begin
                    // request issued once the id register holds the check
                    next_r.tid = T_FWLOAD;
                    next_r.req_pend = 1'b1;
                    next_r.st = S_FWL_WAIT;
                end
            end
            S_PER_DRAIN: begin
                if (IOBUF_EMPTY) begin
                    next_r.tid = T_FIRST_KAT;
                    next_r.periodic = 1'b1;
                    next_r.st = S_PER_REQ;
                end
            end
            S_PCT_WAIT: begin
                if (TEST_DONE) begin
                    if (!TEST_PASS) begin
                        next_r.discard = 1'b1;
                        next_r.op_err = 1'b1;
                        next_r.err = ERR_PCT;
                        next_r.err_tid = T_PCT;
                        next_r.cls = CSTS_CLASS_KEYPAIR;
                        next_r.st = S_LOG;
                    end else begin
                        next_r.st = S_RUN;
                    end
                end
            end
            S_FWL_WAIT: begin
                if (TEST_DONE) begin
                    if (TEST_PASS) begin
                        next_r.fw_accept = 1'b1;
                        next_r.st = S_RUN;
                    end else begin
                        next_r.err = ERR_FW;
                        next_r.err_tid = T_FWLOAD;
                        next_r.st = S_LOG;
                    end
                end
            end
            S_LOG: begin
                next_r.st = S_LOG_WAIT;
            end
            S_LOG_WAIT: begin
                if (FLASH_DONE) begin
                    unique case (r.err)
                        ERR_CRIT: begin
                            next_r.cls = CSTS_CLASS_CRIT;
                            next_r.st = S_CRIT_HALT;
                        end
                        ERR_FW: begin
                            next_r.cls = CSTS_CLASS_FW;
                            next_r.st = S_FW_FAIL;
                        end
                        default: begin
                            next_r.st = S_RUN;
                        end
                    endcase
                end
            end
            S_CRIT_HALT: begin
                next_r.self_reset = 1'b1;
            end
            S_FW_FAIL: begin
                if (NEW_IMAGE_DONE) begin
                    next_r = '0;
                    next_r.st = S_POR;
                    next_r.self_reset = 1'b1;
                end
            end
            default: begin
                next_r.st = S_POR;
            end
        endcase
    end

    // Single state register
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign CMD_READY = (r.st == S_RUN) && !r.due;
    assign IOBUF_HOLD = (r.st == S_PER_REQ) || (r.st == S_PER_WAIT);
    // Requests come from the request states or req_pend, each loaded on the same edge as the id,
    // so an engine never latches the id of the previous test.
    assign TEST_REQ = (r.st == S_PRE_REQ) || (r.st == S_PER_REQ) || r.req_pend;
    assign TEST_ID = r.tid;
    assign KEY_DISCARD = r.discard;
    assign OP_ERR_VALID = r.op_err;
    assign OP_ERR_CODE = r.op_err ? ERR_PCT : ERR_NONE;
    assign RNG_ENABLE = r.rng_ok;
    assign FW_ACCEPT = r.fw_accept;
    assign FLASH_WR = (r.st == S_LOG);
    assign FLASH_ERR = r.err;
    assign FLASH_TID = r.err_tid;
    assign SELF_RESET = r.self_reset;
    assign FLASH_PROG_MODE = (r.st == S_FW_FAIL);
    assign HALTED = (r.st == S_CRIT_HALT);
    // status view
    // Pending covers both a due interval and any run not yet passed,
    // so the command side sees one flag for the whole test window.
    assign TEST_PENDING = r.due || !r.passed;
    assign TESTS_PASSED = r.passed;
    assign ERR_CLASS = r.cls;
endmodule

// [verif/cstsup_chk.sv]
// Port checker for the crypto self-test supervisor.
// Assumes it is bound into cstsup_top; a single clock domain.
`timescale 1ns/1ps
module cstsup_chk #(
    parameter longint unsigned CYC_PER_MIN_P = 1
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic CMD_READY,
    input wire logic IOBUF_EMPTY,
    input wire logic IOBUF_HOLD,
    input wire logic TEST_REQ,
    input wire logic [cstsup_pkg::TID_W-1:0] TEST_ID,
    input wire logic TEST_DONE,
    input wire logic TEST_PASS,
    input wire logic KEY_DISCARD,
    input wire logic OP_ERR_VALID,
    input wire logic [cstsup_pkg::ERR_W-1:0] OP_ERR_CODE,
    input wire logic RNG_ENABLE,
    input wire logic FLASH_WR,
    input wire logic [cstsup_pkg::TID_W-1:0] FLASH_TID,
    input wire logic HALTED,
    input wire logic SELF_RESET,
    input wire logic FLASH_PROG_MODE,
    input wire cstsup_pkg::cstsup_class_t ERR_CLASS
);
    import cstsup_pkg::*;
    logic [4:0] nid;
    // Id that must follow a pass
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N)
            nid <= 5'h00;
        else if (TEST_DONE)
            nid <= TEST_ID + 5'h01;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    property p_req; TEST_REQ |=> !TEST_REQ && $stable(TEST_ID); endproperty
    a_req: assert property (p_req) else $error("request not a one-cycle pulse");
    property p_order; TEST_DONE && TEST_PASS && TEST_ID < T_LAST |-> ##[1:2] TEST_REQ && TEST_ID == nid;
    endproperty
    a_order: assert property (p_order) else $error("next test id out of order");
    property p_log; TEST_DONE && !TEST_PASS && TEST_ID != T_PCT |=> FLASH_WR && FLASH_TID == $past(TEST_ID);
    endproperty
    a_log: assert property (p_log) else $error("failure not logged");
    property p_halt; HALTED |=> HALTED && SELF_RESET && ERR_CLASS == CSTS_CLASS_CRIT; endproperty
    a_halt: assert property (p_halt) else $error("critical halt left");
    property p_fw; FLASH_PROG_MODE |-> !CMD_READY && ERR_CLASS == CSTS_CLASS_FW; endproperty
    a_fw: assert property (p_fw) else $error("commands open in programming mode");
    property p_pct; OP_ERR_VALID |-> OP_ERR_CODE == ERR_PCT && KEY_DISCARD && !HALTED; endproperty
    a_pct: assert property (p_pct) else $error("key pair error report wrong");
    property p_rng; $rose(RNG_ENABLE) |-> $past(TEST_ID) == T_DRBG_RESEED; endproperty
    a_rng: assert property (p_rng) else $error("random output before its tests");
    property p_hold; IOBUF_HOLD |-> !CMD_READY; endproperty
    a_hold: assert property (p_hold) else $error("command taken during periodic test");
    property p_drain; $rose(IOBUF_HOLD) |-> $past(IOBUF_EMPTY); endproperty
    a_drain: assert property (p_drain) else $error("hold before buffer drained");
endmodule
bind cstsup_top cstsup_chk #(.CYC_PER_MIN_P(CYC_PER_MIN_P)) chk_u (.CLK(CLK), .ARST_N(ARST_N),
    .CMD_READY(CMD_READY), .IOBUF_EMPTY(IOBUF_EMPTY), .IOBUF_HOLD(IOBUF_HOLD),
    .TEST_REQ(TEST_REQ), .TEST_ID(TEST_ID), .TEST_DONE(TEST_DONE), .TEST_PASS(TEST_PASS),
    .KEY_DISCARD(KEY_DISCARD), .OP_ERR_VALID(OP_ERR_VALID), .OP_ERR_CODE(OP_ERR_CODE),
    .RNG_ENABLE(RNG_ENABLE), .FLASH_WR(FLASH_WR), .FLASH_TID(FLASH_TID), .HALTED(HALTED),
    .SELF_RESET(SELF_RESET), .FLASH_PROG_MODE(FLASH_PROG_MODE), .ERR_CLASS(ERR_CLASS));

// [verif/cstsup_far_mdl.sv]
// Engine and flash responder on the far side of the supervisor.
// Assumes one test request at a time; answers after one or four cycles.
`timescale 1ns/1ps
module cstsup_far_mdl (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic test_req,
    input wire logic [4:0] test_id,
    input wire logic flash_wr,
    input wire logic [4:0] fail_id,
    input wire logic slow,
    output logic test_done,
    output logic test_pass,
    output logic flash_done
);
    logic [2:0] cnt;
    logic [4:0] id;
    // Pass bit is noise outside done, never a stale result
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 3'h0;
            id <= 5'h00;
            test_done <= 1'b0;
            test_pass <= 1'b0;
            flash_done <= 1'b0;
        end else begin
            test_done <= (cnt == 3'h1);
            test_pass <= (cnt == 3'h1) ? (id != fail_id) : ~test_pass;
            flash_done <= flash_wr;
            if (test_req) begin
                cnt <= slow ? 3'h4 : 3'h1;
                id <= test_id;
            end else if (cnt != 3'h0) begin
                cnt <= cnt - 3'h1;
            end
        end
    end
endmodule

// [verif/testbench.sv]
// Self-checking bench for the crypto self-test supervisor.
// Assumes the far-side model and the checker are compiled before it.
`timescale 1ns/1ps
module testbench;
    import cstsup_pkg::*;
    localparam longint unsigned CPM = 8;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [19:0] ivl = 20'h00000;
    logic cmd_valid = 1'b0, iobuf_empty = 1'b1, keygen = 1'b0, fwload = 1'b0, newimg = 1'b0;
    logic slow = 1'b0;
    logic [4:0] fail_id = 5'h1F;
    logic cmd_ready, iobuf_hold, test_req, test_done, test_pass, flash_wr, flash_done, prog;
    logic key_discard, op_err_valid, rng_enable, fw_accept, self_reset, halted, pending, passed;
    logic [4:0] test_id, flash_tid;
    logic [3:0] op_code, flash_err;
    cstsup_class_t err_class;
    int miscompares = 0;
    int checks_done = 0;
    logic [4:0] ids[$];
    cstsup_top #(.CYC_PER_MIN_P(CPM)) dut_u (.CLK(clk), .ARST_N(arst_n), .INTERVAL_MIN(ivl),
        .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .IOBUF_EMPTY(iobuf_empty),
        .IOBUF_HOLD(iobuf_hold), .TEST_REQ(test_req), .TEST_ID(test_id), .TEST_DONE(test_done),
        .TEST_PASS(test_pass), .KEYGEN_DONE(keygen), .FWLOAD_DONE(fwload),
        .KEY_DISCARD(key_discard), .OP_ERR_CODE(op_code), .OP_ERR_VALID(op_err_valid),
        .RNG_ENABLE(rng_enable), .FW_ACCEPT(fw_accept), .FLASH_WR(flash_wr),
        .FLASH_ERR(flash_err), .FLASH_TID(flash_tid), .FLASH_DONE(flash_done),
        .SELF_RESET(self_reset), .FLASH_PROG_MODE(prog), .HALTED(halted), .TEST_PENDING(pending),
        .TESTS_PASSED(passed), .ERR_CLASS(err_class), .NEW_IMAGE_DONE(newimg));
    cstsup_far_mdl far_u (.clk(clk), .arst_n(arst_n), .test_req(test_req), .test_id(test_id),
        .flash_wr(flash_wr), .fail_id(fail_id), .slow(slow), .test_done(test_done),
        .test_pass(test_pass), .flash_done(flash_done));
    // Clock and request log
    always #25 clk = ~clk;
    always @(posedge clk) if (test_req === 1'b1) ids.push_back(test_id);
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    function automatic logic sel(input int k);
        case (k)
            0: return passed;
            1: return !cmd_ready;
            2: return iobuf_hold;
            3: return cmd_ready;
            4: return op_err_valid;
            5: return fw_accept;
            6: return flash_wr;
            7: return halted;
            8: return prog;
            default: return self_reset;
        endcase
    endfunction
    // Bounded wait; a timeout shows as a mismatch
    task automatic wfor(input int k, input string nm);
        int n = 0;
        while (sel(k) !== 1'b1 && n < 3000) begin
            tick();
            n++;
        end
        chk(nm, 1, sel(k));
    endtask
    task automatic do_reset(input logic [4:0] f);
        arst_n <= 1'b0;
        fail_id <= f;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        ids.delete();
    endtask
    task automatic pulse(input int k);
        @(posedge clk);
        case (k)
            0: keygen <= 1'b1;
            1: fwload <= 1'b1;
            default: newimg <= 1'b1;
        endcase
        @(posedge clk);
        keygen <= 1'b0;
        fwload <= 1'b0;
        newimg <= 1'b0;
        #1;
    endtask
    task automatic t_power;
        do_reset(5'h1F);
        tick();
        chk("rng_early", 0, rng_enable);
        wfor(0, "tests_passed");
        chk("powerup_count", 17, ids.size());
        foreach (ids[i]) chk("powerup_id", i, ids[i]);
        chk("rng_enable", 1, rng_enable);
        chk("class_ok", CSTS_CLASS_OK, err_class);
        chk("pending_clear", 0, pending);
        $display("test power_up done");
    endtask
    task automatic t_cmds;
        fail_id <= T_PCT;
        ids.delete();
        pulse(0);
        wfor(4, "pct_error");
        chk("pct_id", T_PCT, ids[0]);
        chk("pct_code", ERR_PCT, op_code);
        wfor(3, "ready_after_pct");
        fail_id <= 5'h1F;
        ids.delete();
        pulse(1);
        wfor(5, "fw_accept");
        chk("fwload_id", T_FWLOAD, ids[0]);
        $display("test commands done");
    endtask
    task automatic t_periodic;
        int n = 0;
        slow <= 1'b1;
        iobuf_empty <= 1'b0;
        cmd_valid <= 1'b1;
        ivl <= 20'h00001;
        ids.delete();
        wfor(1, "interval_due");
        repeat (4) begin
            tick();
            chk("hold_early", 0, iobuf_hold);
            chk("ready_refused", 0, cmd_ready);
            chk("pending_due", 1, pending);
        end
        chk("no_test_before_drain", 0, ids.size());
        iobuf_empty <= 1'b1;
        wfor(2, "hold_in_test");
        wfor(3, "ready_after_test");
        chk("first_periodic", T_FIRST_KAT, ids[0]);
        chk("periodic_count", 14, ids.size());
        while (cmd_ready === 1'b1 && n < 50) begin
            tick();
            n++;
        end
        chk("reload_gap", 1, n >= CPM - 2 && n <= CPM + 3);
        wfor(3, "ready_again");
        ivl <= IVL_OFF;
        repeat (60) tick();
        chk("off_stays_ready", 1, cmd_ready);
        $display("test periodic done");
    endtask
    task automatic t_crit(input logic [4:0] f);
        do_reset(f);
        wfor(6, "crit_logged");
        chk("crit_err", ERR_CRIT, flash_err);
        chk("crit_tid", f, flash_tid);
        wfor(7, "halted");
        repeat (20) tick();
        chk("self_reset", 1, self_reset);
        chk("crit_class", CSTS_CLASS_CRIT, err_class);
        $display("test critical done");
    endtask
    task automatic t_fw(input logic [4:0] f);
        slow <= 1'b0;
        do_reset(f);
        wfor(6, "fw_logged");
        chk("fw_err", ERR_FW, flash_err);
        wfor(8, "prog_mode");
        chk("fw_rng_off", 0, rng_enable);
        fail_id <= 5'h1F;
        pulse(2);
        wfor(9, "reflash_restart");
        wfor(0, "passed_after_reflash");
        $display("test firmware done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Main sequence
    initial begin
        t_power();
        t_cmds();
        t_periodic();
        t_crit(T_AES_CFB_E);
        t_crit(T_HMAC384);
        t_crit(T_DRBG_GEN);
        t_fw(T_SHA256);
        t_fw(T_RSAVER);
        t_fw(T_FWSIG);
        wrap_up();
    end
    // Watchdog, many times the expected run of under a thousand cycles
    initial begin
        #(20000 * 50);
        miscompares++;
        wrap_up();
    end
endmodule
